// ==== core/channel_settings_decode.sv ====
// decodes one channel's three settings bytes into control fields
`timescale 1ns/100ps
`include "sensor_channel_map.svh"
module channel_settings_decode (
  input  wire logic [7:0]                      mode_byte,     // sense mode settings
  input  wire logic [7:0]                      timing_byte,   // charge timing settings
  input  wire logic [7:0]                      tune_byte,     // auto tune settings
  output sensor_channel_pkg::sense_mode_e      sense_mode,    // sensing mode
  output logic                                 inductive,     // inductive selected
  output logic [1:0]                           receive_enable, // bit0 electrode zero
  output logic                                 small_range,   // multiplier range small
  output logic                                 large_store,   // 60 pf store when high
  output sensor_channel_pkg::freq_div_e        freq_div,      // charge frequency divider
  output logic [4:0]                           div_ratio,     // divide ratio 2..16
  output sensor_channel_pkg::tune_mode_e       tune_mode,     // auto tuning mode
  output logic [9:0]                           tuning_base_value,   // base count
  output logic [10:0]                          tuning_target_value  // target count
);
  import sensor_channel_pkg::*;
  // field extraction; ranges stay meaningful only in inductive mode
  always_comb begin
    sense_mode     = sense_mode_e'(mode_byte[7:6]);
    inductive      = (mode_byte[7:6] == `MODE_IND);
    receive_enable = mode_byte[1:0];
    small_range    = inductive & mode_byte[4];
    large_store    = timing_byte[6];
    freq_div       = freq_div_e'(timing_byte[5:4]);
    tune_mode      = tune_mode_e'(timing_byte[1:0]);
    tuning_target_value = {tune_byte[5:0], 5'h00};
    unique case (timing_byte[5:4])
      2'b00: div_ratio = 5'h02;
      2'b01: div_ratio = 5'h04;
      2'b10: div_ratio = 5'h08;
      2'b11: div_ratio = 5'h10;
    endcase
    unique case (tune_byte[7:6])
      2'b00: tuning_base_value = `BASE_75;
      2'b01: tuning_base_value = `BASE_100;
      2'b10: tuning_base_value = `BASE_150;
      2'b11: tuning_base_value = `BASE_200;
    endcase
  end
endmodule : channel_settings_decode

// ==== core/sensor_channel_map.svh ====
// register map, field positions and reset values of the channel register block
`ifndef SENSOR_CHANNEL_MAP_SVH
`define SENSOR_CHANNEL_MAP_SVH
`define COUNT_BASE      8'h20
`define COUNT_LAST      8'h2b
`define AVERAGE_BASE    8'h30
`define AVERAGE_LAST    8'h35
`define MODE_BASE       8'h40
`define TIMING_BASE     8'h43
`define TUNE_BASE       8'h46
`define MODE_RESET      8'h00
`define TIMING_RESET    8'h67
`define TUNE_RESET      8'hd0
`define VALUE_RESET     16'h0000
`define RDATA_RESET     8'h00
`define RDATA_UNMAPPED  8'h00
`define MODE_CAP        2'b00
`define MODE_IND        2'b10
`define TARGET_SHIFT    5
`define BASE_75         10'h04b
`define BASE_100        10'h064
`define BASE_150        10'h096
`define BASE_200        10'h0c8
`endif

// ==== core/sensor_channel_pkg.sv ====
// types shared by the channel register block
package sensor_channel_pkg;
  typedef enum logic [1:0] {sense_capacitive, sense_reserved_a, sense_inductive,
                            sense_reserved_b} sense_mode_e;
  typedef enum logic [1:0] {tune_off, tune_partial, tune_semi_partial, tune_full} tune_mode_e;
  typedef enum logic [1:0] {div_half, div_quarter, div_eighth, div_sixteenth} freq_div_e;
endpackage : sensor_channel_pkg

// ==== core/sensor_channel_regs.sv ====
// channel count, long term average and settings register bank
`timescale 1ns/100ps
`include "sensor_channel_map.svh"
module sensor_channel_regs #(
  parameter int COUNT_CHANNELS = 4,  // channels with raw counts
  parameter int SENSE_CHANNELS = 3   // channels with averages and settings
) (
  input  wire logic                              clk,          // 100 mhz clock
  input  wire logic                              reset,        // sync reset, high
  input  wire logic [7:0]                        reg_addr,     // register byte address
  input  wire logic                              reg_write,    // write strobe
  input  wire logic                              reg_read,     // read strobe
  input  wire logic [7:0]                        reg_wdata,    // write data
  output logic [7:0]                             reg_rdata,    // registered read data
  input  wire logic                              cycle_done,   // measurement cycle pulse
  input  wire logic [COUNT_CHANNELS*16-1:0]      meas_count,   // new counts per channel
  input  wire logic [SENSE_CHANNELS*16-1:0]      meas_average, // new averages per channel
  output logic [SENSE_CHANNELS*2-1:0]            sense_mode,   // mode per channel
  output logic [SENSE_CHANNELS-1:0]              inductive,    // inductive per channel
  output logic [SENSE_CHANNELS*2-1:0]            receive_enable, // electrodes per channel
  output logic [SENSE_CHANNELS-1:0]              small_range,  // multiplier range
  output logic [SENSE_CHANNELS-1:0]              large_store,  // charge store size
  output logic [SENSE_CHANNELS*5-1:0]            div_ratio,    // frequency divide ratio
  output logic [SENSE_CHANNELS*2-1:0]            tune_mode,    // auto tuning mode
  output logic [SENSE_CHANNELS*10-1:0]           tuning_base_value,   // base counts
  output logic [SENSE_CHANNELS*11-1:0]           tuning_target_value  // target counts
);
  import sensor_channel_pkg::*;
  logic [15:0] count [COUNT_CHANNELS];
  logic [15:0] average [SENSE_CHANNELS];
  logic [7:0]  mode_reg [SENSE_CHANNELS];
  logic [7:0]  timing_reg [SENSE_CHANNELS];
  logic [7:0]  tune_reg [SENSE_CHANNELS];
  logic [7:0]  held_high, next_held_high; // high byte latched on low-byte read
  logic [7:0]  next_rdata;

  // per-channel storage and decode
  for (genvar c = 0; c < COUNT_CHANNELS; c++) begin : g_count
    logic [15:0] next_count;
    always_comb begin
      next_count = count[c];
      if (cycle_done) next_count = meas_count[c*16 +: 16];
    end
    always_ff @(posedge clk) begin
      if (reset) count[c] <= `VALUE_RESET;
      else count[c] <= next_count;
    end
    // every count copy loads on the pulse and holds otherwise; host writes never reach it
    count_load_a: assert property (@(posedge clk) disable iff (reset)
      cycle_done |=> count[c] == $past(meas_count[c*16 +: 16]))
      else $error("count copy stale");
    count_keep_a: assert property (@(posedge clk) disable iff (reset)
      !cycle_done |=> $stable(count[c]))
      else $error("count copy moved");
  end
  for (genvar c = 0; c < SENSE_CHANNELS; c++) begin : g_sense
    logic [15:0] next_average;
    logic [7:0]  next_mode, next_timing, next_tune;
    sense_mode_e sm;
    freq_div_e   fd;
    tune_mode_e  tm;
    // host writes win over a same-cycle average update, so software overrides stick
    always_comb begin
      next_average = average[c];
      next_mode    = mode_reg[c];
      next_timing  = timing_reg[c];
      next_tune    = tune_reg[c];
      if (cycle_done) next_average = meas_average[c*16 +: 16];
      if (reg_write) begin
        if (reg_addr == `AVERAGE_BASE + 8'(2*c)) next_average[7:0] = reg_wdata;
        if (reg_addr == `AVERAGE_BASE + 8'(2*c+1)) next_average[15:8] = reg_wdata;
        if (reg_addr == `MODE_BASE + 8'(c)) next_mode = reg_wdata;
        if (reg_addr == `TIMING_BASE + 8'(c)) next_timing = reg_wdata;
        if (reg_addr == `TUNE_BASE + 8'(c)) next_tune = reg_wdata;
      end
    end
    always_ff @(posedge clk) begin
      if (reset) begin
        average[c]    <= `VALUE_RESET;
        mode_reg[c]   <= `MODE_RESET;
        timing_reg[c] <= `TIMING_RESET;
        tune_reg[c]   <= `TUNE_RESET;
      end else begin
        average[c]    <= next_average;
        mode_reg[c]   <= next_mode;
        timing_reg[c] <= next_timing;
        tune_reg[c]   <= next_tune;
      end
    end
    channel_settings_decode u_decode (
      .mode_byte           (mode_reg[c]),
      .timing_byte         (timing_reg[c]),
      .tune_byte           (tune_reg[c]),
      .sense_mode          (sm),
      .inductive           (inductive[c]),
      .receive_enable      (receive_enable[c*2 +: 2]),
      .small_range         (small_range[c]),
      .large_store         (large_store[c]),
      .freq_div            (fd),
      .div_ratio           (div_ratio[c*5 +: 5]),
      .tune_mode           (tm),
      .tuning_base_value   (tuning_base_value[c*10 +: 10]),
      .tuning_target_value (tuning_target_value[c*11 +: 11])
    );
    assign sense_mode[c*2 +: 2] = sm;
    assign tune_mode[c*2 +: 2]  = tm;
    // inductive needs both electrodes; host owns that, the device does not force it
    store_select_a: assert property (@(posedge clk) disable iff (reset)
      large_store[c] == timing_reg[c][6]) else $error("store size wrong");
    inductive_rx_a: assert property (@(posedge clk) disable iff (reset)
      inductive[c] |-> receive_enable[c*2 +: 2] == 2'b11) else $error("rx not both");
    // every decoder copy is checked, since the bench spreads its codes over all channels
    mode_select_a: assert property (@(posedge clk) disable iff (reset)
      sm == sense_mode_e'(mode_reg[c][7:6]))
      else $error("mode copy wrong");
    rx_select_a: assert property (@(posedge clk) disable iff (reset)
      receive_enable[c*2 +: 2] == mode_reg[c][1:0])
      else $error("rx copy wrong");
    range_select_a: assert property (@(posedge clk) disable iff (reset)
      small_range[c] == (inductive[c] && mode_reg[c][4]))
      else $error("range copy wrong");
    divider_select_a: assert property (@(posedge clk) disable iff (reset)
      div_ratio[c*5 +: 5] == 5'(5'h02 << timing_reg[c][5:4]) && fd == freq_div_e'(timing_reg[c][5:4]))
      else $error("divider copy wrong");
    tune_select_a: assert property (@(posedge clk) disable iff (reset)
      tm == tune_mode_e'(timing_reg[c][1:0]))
      else $error("tune copy wrong");
    base_select_a: assert property (@(posedge clk) disable iff (reset)
      tuning_base_value[c*10 +: 10] == (tune_reg[c][7] ?
        (tune_reg[c][6] ? `BASE_200 : `BASE_150) : (tune_reg[c][6] ? `BASE_100 : `BASE_75)))
      else $error("base copy wrong");
    target_select_a: assert property (@(posedge clk) disable iff (reset)
      tuning_target_value[c*11 +: 11] == 11'(tune_reg[c][5:0]) * 11'h020)
      else $error("target copy wrong");
    // a pulse with no host write in the same cycle must land whole in the average
    average_load_a: assert property (@(posedge clk) disable iff (reset)
      cycle_done && !reg_write |=> average[c] == $past(meas_average[c*16 +: 16]))
      else $error("average copy stale");
    mode_write_a: assert property (@(posedge clk) disable iff (reset)
      reg_write && reg_addr == `MODE_BASE + 8'(c) |=> mode_reg[c] == $past(reg_wdata))
      else $error("mode write lost");
  end

  // read mux: reading a low byte freezes the high byte so a pair never mixes cycles
  always_comb begin
    next_rdata     = `RDATA_UNMAPPED;
    next_held_high = held_high;
    for (int c = 0; c < COUNT_CHANNELS; c++) begin
      if (reg_addr == `COUNT_BASE + 8'(2*c)) begin
        next_rdata = count[c][7:0];
        if (reg_read) next_held_high = count[c][15:8];
      end
      if (reg_addr == `COUNT_BASE + 8'(2*c+1)) next_rdata = held_high;
    end
    for (int c = 0; c < SENSE_CHANNELS; c++) begin
      if (reg_addr == `AVERAGE_BASE + 8'(2*c)) begin
        next_rdata = average[c][7:0];
        if (reg_read) next_held_high = average[c][15:8];
      end
      if (reg_addr == `AVERAGE_BASE + 8'(2*c+1)) next_rdata = held_high;
      if (reg_addr == `MODE_BASE + 8'(c)) next_rdata = mode_reg[c];
      if (reg_addr == `TIMING_BASE + 8'(c)) next_rdata = timing_reg[c];
      if (reg_addr == `TUNE_BASE + 8'(c)) next_rdata = tune_reg[c];
    end
    if (!reg_read) next_rdata = reg_rdata;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= `RDATA_RESET;
      held_high <= `RDATA_RESET;
    end else begin
      reg_rdata <= next_rdata;
      held_high <= next_held_high;
    end
  end

  count_update_a: assert property (@(posedge clk) disable iff (reset)
    cycle_done |=> count[0] == $past(meas_count[15:0])) else $error("count stale");
  count_hold_a: assert property (@(posedge clk) disable iff (reset)
    !cycle_done |=> $stable(count[0])) else $error("count moved");
  average_write_a: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == `AVERAGE_BASE |=> average[0][7:0] == $past(reg_wdata))
    else $error("average write lost");
  settings_write_a: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == `TIMING_BASE + 8'h01 |=> timing_reg[1] == $past(reg_wdata))
    else $error("settings write lost");
  mode_decode_a: assert property (@(posedge clk) disable iff (reset)
    inductive[0] == (mode_reg[0][7:6] == `MODE_IND)) else $error("mode wrong");
  range_decode_a: assert property (@(posedge clk) disable iff (reset)
    small_range[0] == (inductive[0] && mode_reg[0][4])) else $error("range wrong");
  divider_decode_a: assert property (@(posedge clk) disable iff (reset)
    div_ratio[4:0] == 5'(5'h02 << timing_reg[0][5:4])) else $error("divider wrong");
  target_scale_a: assert property (@(posedge clk) disable iff (reset)
    tuning_target_value[10:0] == 11'(tune_reg[0][5:0]) * 11'h020)
    else $error("target wrong");
  base_default_a: assert property (@(posedge clk) disable iff (reset)
    tune_reg[0][7:6] == 2'b11 |-> tuning_base_value[9:0] == `BASE_200)
    else $error("base wrong");
  tune_decode_a: assert property (@(posedge clk) disable iff (reset)
    tune_mode[1:0] == timing_reg[0][1:0]) else $error("tune mode wrong");
  rx_decode_a: assert property (@(posedge clk) disable iff (reset)
    receive_enable[1:0] == mode_reg[0][1:0]) else $error("rx wrong");
  read_pair_a: assert property (@(posedge clk) disable iff (reset)
    reg_read && reg_addr == `COUNT_BASE ##1 reg_read && reg_addr == `COUNT_BASE + 8'h01
    |=> reg_rdata == $past(count[0][15:8], 2)) else $error("pair torn");
  // holes in the map read as zero so software probing the bank sees no stale byte
  unmapped_read_a: assert property (@(posedge clk) disable iff (reset)
    reg_read && reg_addr > `TUNE_BASE + 8'(SENSE_CHANNELS-1) |=> reg_rdata == `RDATA_UNMAPPED)
    else $error("unmapped read not zero");
  read_hold_a: assert property (@(posedge clk) disable iff (reset)
    !reg_read |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule : sensor_channel_regs

// ==== test/sensor_host.sv ====
// host model that reaches the channel registers over the byte strobe access
`timescale 1ns/100ps
module sensor_host (
  input  wire logic       clk,       // register clock
  output logic [7:0]      reg_addr,  // byte address
  output logic            reg_write, // write strobe
  output logic            reg_read,  // read strobe
  output logic [7:0]      reg_wdata, // write data
  input  wire logic [7:0] reg_rdata  // read data
);
  initial begin
    reg_addr  = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_wdata = 8'h00;
  end
  // idle bus is inverted so nothing leans on a stale address or data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a >= 8'h40 && a <= 8'h42 && d[7:6] == 2'b10) begin
      v[1:0] = 2'b11;
    end
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~v;
    // decodes change at the taking edge, so callers look just after it
    #1;
  endtask : wr
  // low byte then high byte on consecutive edges, the tightest pair the bank allows
  task automatic rd_pair(input logic [7:0] a, output logic [7:0] lo, output logic [7:0] hi);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_addr <= a + 8'h01;
    #1;
    lo = reg_rdata;
    @(posedge clk);
    reg_read <= 1'b0;
    reg_addr <= ~(a + 8'h01);
    #1;
    hi = reg_rdata;
  endtask : rd_pair
  // read data lands at the taking edge, so sample just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : sensor_host

// ==== test/tb_sensor_channel_regs.sv ====
// self-checking bench for the channel register bank
`timescale 1ns/100ps
module tb_sensor_channel_regs;
  logic        clk, reset, reg_write, reg_read, cycle_done;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [63:0] meas_count;
  logic [47:0] meas_average;
  logic [5:0]  sense_mode, receive_enable, tune_mode;
  logic [2:0]  inductive, small_range, large_store;
  logic [14:0] div_ratio;
  logic [29:0] tuning_base_value;
  logic [32:0] tuning_target_value;
  int          mismatches, n_tests;
  logic [7:0]  lo, hi;
  int          bases[4] = '{75, 100, 150, 200};
  sensor_channel_regs #(.COUNT_CHANNELS(4), .SENSE_CHANNELS(3)) sensor_channel_regs_i (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cycle_done(cycle_done), .meas_count(meas_count), .meas_average(meas_average),
    .sense_mode(sense_mode), .inductive(inductive), .receive_enable(receive_enable),
    .small_range(small_range), .large_store(large_store), .div_ratio(div_ratio),
    .tune_mode(tune_mode), .tuning_base_value(tuning_base_value),
    .tuning_target_value(tuning_target_value));
  sensor_host sensor_host_i (.clk(clk), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    sensor_host_i.rd(a, d);
    chk({24'h0, d}, {24'h0, exp});
  endtask : rchk
  // one measurement cycle pulse carrying new counts and averages
  task automatic pulse(input logic [63:0] cnt, input logic [47:0] avg);
    @(posedge clk);
    meas_count   <= cnt;
    meas_average <= avg;
    cycle_done   <= 1'b1;
    @(posedge clk);
    cycle_done <= 1'b0;
  endtask : pulse
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  // a hang is cut off long after the roughly 150 cycles the tests need
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    cycle_done = 1'b0;
    meas_count = '0;
    meas_average = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    // reset value of every settings copy and its timing and tune decodes
    for (int c = 0; c < 3; c++) begin
      rchk(8'h40 + 8'(c), 8'h00);
      rchk(8'h43 + 8'(c), 8'h67);
      rchk(8'h46 + 8'(c), 8'hd0);
      chk(32'(div_ratio[c*5 +: 5]), 8);
      chk(32'(large_store[c]), 1);
      chk(32'(tune_mode[c*2 +: 2]), 3);
      chk(32'(tuning_base_value[c*10 +: 10]), 200);
      chk(32'(tuning_target_value[c*11 +: 11]), 512);
    end
    // a new cycle between low and high reads must not tear the value;
    // the average read goes first because every low read reloads the shared high latch
    for (int c = 0; c < 4; c++) begin
      pulse(64'h4a49_3a39_2a29_1a19, 48'h3c3b_2c2b_1c1b);
      if (c < 3) rchk(8'h30 + 8'(2*c), 8'h1b + 8'(16*c));
      rchk(8'h20 + 8'(2*c), 8'h19 + 8'(16*c));
      pulse('1, '1);
      rchk(8'h21 + 8'(2*c), 8'h1a + 8'(16*c));
    end
    sensor_host_i.wr(8'h20, 8'h00);
    rchk(8'h20, 8'hff);
    rchk(8'h60, 8'h00);
    // host overwrites each average, then a cycle reloads it
    for (int c = 0; c < 3; c++) begin
      sensor_host_i.wr(8'h30 + 8'(2*c), 8'h5a + 8'(c));
      sensor_host_i.wr(8'h31 + 8'(2*c), 8'ha5);
      rchk(8'h30 + 8'(2*c), 8'h5a + 8'(c));
      rchk(8'h31 + 8'(2*c), 8'ha5);
    end
    pulse(64'h0000_0000_0000_c3d4, 48'h3c3b_2c2b_1c1b);
    rchk(8'h34, 8'h3b);
    rchk(8'h35, 8'h3c);
    // back to back low and high reads of one count
    sensor_host_i.rd_pair(8'h20, lo, hi);
    chk({24'h0, lo}, 32'h0000_00d4);
    chk({24'h0, hi}, 32'h0000_00c3);
    // every receive select code in capacitive mode
    for (int k = 0; k < 4; k++) begin
      sensor_host_i.wr(8'h40 + 8'(k % 3), 8'(k));
      chk(32'(receive_enable[(k%3)*2 +: 2]), k);
      chk(32'(sense_mode[(k%3)*2 +: 2]), 0);
      chk(32'(inductive[k%3]), 0);
    end
    // inductive mode with both multiplier ranges
    for (int k = 0; k < 2; k++) begin
      sensor_host_i.wr(8'h41, 8'h80 + 8'(16*k));
      chk(32'(sense_mode[3:2]), 2);
      chk(32'(inductive[1]), 1);
      chk(32'(small_range[1]), k);
      chk(32'(receive_enable[3:2]), 3);
    end
    // store size, divider and tuning mode codes
    for (int k = 0; k < 4; k++) begin
      sensor_host_i.wr(8'h43 + 8'(k % 3), 8'(64*(k%2) + 16*k + 4 + 3 - k));
      chk(32'(large_store[k%3]), k % 2);
      chk(32'(div_ratio[(k%3)*5 +: 5]), 2 << k);
      chk(32'(tune_mode[(k%3)*2 +: 2]), 3 - k);
    end
    // base codes and target field corners
    for (int k = 0; k < 4; k++) begin
      sensor_host_i.wr(8'h46 + 8'(k % 3), 8'(64*k + 21*k));
      rchk(8'h46 + 8'(k % 3), 8'(64*k + 21*k));
      chk(32'(tuning_base_value[(k%3)*10 +: 10]), bases[k]);
      chk(32'(tuning_target_value[(k%3)*11 +: 11]), 21*k*32);
    end
    // a second reset in mid-run brings the settings back to their defaults
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    chk({24'h0, reg_rdata}, 32'h0);
    reset <= 1'b0;
    rchk(8'h43, 8'h67);
    rchk(8'h46, 8'hd0);
    chk(32'(div_ratio[4:0]), 8);
    end_of_test();
  end
endmodule : tb_sensor_channel_regs
